//--- sbs_pkg.sv
// Constants, types and helpers shared by the synchronous burst SRAM port
// -----------------------------------------------------------------------
// Overview of operation
// - Accepted processor strobe loads the presented address into the address register.
// - Accepted controller strobe loads the presented address into the address register.
// - Every accepted strobe loads address bits [1:0] as the burst start.
// - With both strobes low and the primary chip select low, only the processor strobe is acted on.
// - Processor strobe is ignored while the primary chip select is high.
// - Sleep request puts the port into sleep; stored contents are kept.
// - Sleep input low or open means normal operation; pad pull-down assumed.
// - Write data on the data lines is captured at the rising edge.
// - Read data is the word addressed at the preceding rising edge.
// - Data drive only while output enable is low; parity lines likewise.
// - Outputs float during write data, first cycle after deselect, and deselected.
// - Parity lines act like data; each parity bit written by its lane.
// - Burst order strap: low linear, high or open interleaved, kept static.
// - Burst step low during a burst advances the counter.
// - Global write writes all lanes, ignoring byte enable and lane selects.
// - Each lane select, qualified by byte enable, writes only its lane.
// - Counter wraps in four: linear adds modulo four, interleaved XORs.
// -----------------------------------------------------------------------
package sbs_pkg;

    localparam int ADDR_W = 19;
    localparam int MEM_AW = 8;
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 2;
    localparam int CLK_PERIOD_NS = 20;
    // Entering sleep takes two clock cycles
    localparam int SLEEP_ENTRY_CYCLES = 2;
    localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_ENTRY_CYCLES - 1);
    localparam logic [3:0] LANES_ALL = 4'hf;
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [1:0] STEP_RESET = 2'h0;

    // AXI4-Lite register map (byte addresses)
    localparam int AXI_AW = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADDR = 4'h8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CTRL_FORCE_SLEEP = 0;
    localparam int CTRL_DRAIN_HOLD = 1;
    localparam int STAT_FULL = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {ST_DESEL, ST_FIRST, ST_ACTIVE, ST_SLEEP} sbs_state_e;

    typedef struct packed {
        logic [MEM_AW-1:0] idx;
        logic [31:0] data;
        logic [LANES-1:0] par;
        logic [LANES-1:0] mask;
    } sbs_wr_s;

    // Two-bit wrapping burst sequence
    function automatic logic [1:0] sbs_burst_lo(input logic [1:0] start,
                                                input logic [1:0] step,
                                                input logic linear);
        sbs_burst_lo = linear ? 2'(start + step) : (start ^ step);
    endfunction

    function automatic logic sbs_reg_mapped(input logic [AXI_AW-1:0] addr);
        sbs_reg_mapped = (addr == REG_CTRL) || (addr == REG_STATUS) || (addr == REG_ADDR);
    endfunction

endpackage

//--- sbs_fifo.sv
// Small valid/ready buffer for pending memory writes
`timescale 1ns/1ps
module sbs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

    logic [W-1:0] buf_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != CNT_FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = buf_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge CLK) begin
        if (push) begin
            buf_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PTR_LAST) ? '0 : PW'(wp_q + 1'b1);
            end
            if (pop) begin
                rp_q <= (rp_q == PTR_LAST) ? '0 : PW'(rp_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= (PW + 1)'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= (PW + 1)'(cnt_q - 1'b1);
            end
        end
    end

endmodule // sbs_fifo

//--- sbs_port.sv
// Synchronous flow-through burst SRAM port with AXI4-Lite status/control
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sbs_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Address and burst control
    input wire logic [sbs_pkg::ADDR_W-1:0] ADDR,
    input wire logic PROC_ADDR_STROBE_N,
    input wire logic CTRL_ADDR_STROBE_N,
    input wire logic PRIMARY_CHIP_SELECT_N,
    input wire logic BURST_STEP_N,
    input wire logic BURST_ORDER_MODE,
    // Write qualification
    input wire logic GLOBAL_WRITE_N,
    input wire logic BYTE_WRITE_ENABLE_N,
    input wire logic [sbs_pkg::LANES-1:0] BYTE_LANE_SELECT_N,
    output logic WRITE_READY,
    // Output enable and sleep
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQUEST,
    // Data and parity pins
    input wire logic [31:0] DQ_I,
    output logic [31:0] DQ_O,
    output logic DQ_OE,
    input wire logic [sbs_pkg::LANES-1:0] PARITY_IO_I,
    output logic [sbs_pkg::LANES-1:0] PARITY_IO_O,
    output logic PARITY_IO_OE,
    // AXI4-Lite slave
    input wire logic [sbs_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [sbs_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import sbs_pkg::*;

    sbs_state_e state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] start_q;
    logic [1:0] step_q;
    logic [1:0] sleep_cnt_q;
    logic [1:0] ctrl_q;
    logic [35:0] mem_q [2**MEM_AW];
    logic [35:0] rd_q;

    logic sleeping;
    logic in_burst;
    logic proc_acc;
    logic ctrl_acc;
    logic strobe_acc;
    logic [LANES-1:0] wr_mask;
    logic wr_inputs;
    logic push_valid;
    logic push_ready;
    logic sleep_req;
    logic sleep_ent;
    logic linear;
    logic [1:0] lo_in;
    logic [1:0] start_d;
    logic [1:0] step_d;
    logic [ADDR_W-1:0] addr_d;
    logic [MEM_AW-1:0] eff_idx;
    logic dq_drive;
    sbs_wr_s push_data;
    sbs_wr_s drain_data;
    logic drain_valid;
    logic drain_ready;
    logic drain_fire;

    // -----------------------------------------------------------------
    // Strobe qualification
    // -----------------------------------------------------------------
    assign sleeping = (state_q == ST_SLEEP);
    assign in_burst = (state_q == ST_FIRST) || (state_q == ST_ACTIVE);
    assign proc_acc = !sleeping && !PROC_ADDR_STROBE_N && !PRIMARY_CHIP_SELECT_N;
    // Controller strobe loses whenever the processor strobe is recognised
    assign ctrl_acc = !sleeping && !CTRL_ADDR_STROBE_N && !proc_acc;
    assign strobe_acc = proc_acc || ctrl_acc;
    // Open strap reads high through the pad pull-up, giving interleaved order
    assign linear = !BURST_ORDER_MODE;
    assign lo_in = ADDR[1:0];

    // -----------------------------------------------------------------
    // Write qualification
    // -----------------------------------------------------------------
    always_comb begin
        if (!GLOBAL_WRITE_N) begin
            wr_mask = LANES_ALL;
        end else if (!BYTE_WRITE_ENABLE_N) begin
            wr_mask = ~BYTE_LANE_SELECT_N;
        end else begin
            wr_mask = LANES_NONE;
        end
    end
    assign wr_inputs = (wr_mask != LANES_NONE);
    // Write inputs are ignored on the processor strobe's own cycle
    assign push_valid = wr_inputs && ((ctrl_acc && !PRIMARY_CHIP_SELECT_N)
                        || (!strobe_acc && !sleeping && in_burst));
    assign WRITE_READY = push_ready;

    // -----------------------------------------------------------------
    // Address register and burst counter
    // -----------------------------------------------------------------
    always_comb begin
        addr_d = addr_q;
        start_d = start_q;
        step_d = step_q;
        if (strobe_acc) begin
            addr_d = ADDR;
            start_d = lo_in;
            step_d = STEP_RESET;
        end else if (in_burst && !sleeping && !BURST_STEP_N) begin
            step_d = 2'(step_q + 2'h1);
        end
    end
    assign eff_idx = {addr_d[MEM_AW-1:2], sbs_burst_lo(start_d, step_d, linear)};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            addr_q <= '0;
            start_q <= STEP_RESET;
            step_q <= STEP_RESET;
        end else begin
            addr_q <= addr_d;
            start_q <= start_d;
            step_q <= step_d;
        end
    end

    // -----------------------------------------------------------------
    // Select and sleep sequencing
    // -----------------------------------------------------------------
    // Pin without a driver reads low via the pad pull-down: normal operation
    assign sleep_req = SLEEP_REQUEST || ctrl_q[CTRL_FORCE_SLEEP];
    assign sleep_ent = sleep_req && (sleep_cnt_q == SLEEP_CNT_LAST);

    always_ff @(posedge CLK) begin
        if (SYS_RST || !sleep_req) begin
            sleep_cnt_q <= '0;
        end else if (sleep_cnt_q != SLEEP_CNT_LAST) begin
            sleep_cnt_q <= 2'(sleep_cnt_q + 2'h1);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= ST_DESEL;
        end else begin
            case (state_q)
                ST_SLEEP: begin
                    if (!sleep_req) begin
                        state_q <= ST_DESEL;
                    end
                end
                ST_DESEL, ST_FIRST, ST_ACTIVE: begin
                    if (sleep_ent) begin
                        state_q <= ST_SLEEP;
                    end else if (strobe_acc) begin
                        if (PRIMARY_CHIP_SELECT_N) begin
                            state_q <= ST_DESEL;
                        end else if (state_q == ST_DESEL) begin
                            state_q <= ST_FIRST;
                        end else begin
                            state_q <= ST_ACTIVE;
                        end
                    end else if (state_q == ST_FIRST) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_q <= ST_DESEL;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Write path: capture, buffer, commit to the array
    // -----------------------------------------------------------------
    assign push_data.idx = eff_idx;
    assign push_data.data = DQ_I;
    assign push_data.par = PARITY_IO_I;
    assign push_data.mask = wr_mask;
    // Sleep or software hold stalls commits so the buffer can fill
    assign drain_ready = !sleeping && !ctrl_q[CTRL_DRAIN_HOLD];
    assign drain_fire = drain_valid && drain_ready;

    sbs_fifo #(
        .W($bits(sbs_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_buf (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    always_ff @(posedge CLK) begin
        if (drain_fire) begin
            for (int k = 0; k < LANES; k++) begin
                if (drain_data.mask[k]) begin
                    mem_q[drain_data.idx][8*k +: 8] <= drain_data.data[8*k +: 8];
                    mem_q[drain_data.idx][32 + k] <= drain_data.par[k];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Read path and pin direction
    // -----------------------------------------------------------------
    // A word still waiting in the buffer is not forwarded to reads
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[eff_idx];
        end
    end
    assign DQ_O = rd_q[31:0];
    assign PARITY_IO_O = rd_q[35:32];
    assign dq_drive = !OUTPUT_ENABLE_N && (state_q == ST_ACTIVE) && !wr_inputs;
    assign DQ_OE = dq_drive;
    assign PARITY_IO_OE = dq_drive;

    // -----------------------------------------------------------------
    // AXI4-Lite slave
    // -----------------------------------------------------------------
    logic aw_hold_q;
    logic w_hold_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [31:0] rd_word;

    assign S_AXI_AWREADY = !aw_hold_q && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_hold_q && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign wr_fire = aw_hold_q && w_hold_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_fire && awaddr_q == REG_CTRL && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= sbs_reg_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_comb begin
        rd_word = '0;
        case (S_AXI_ARADDR)
            REG_CTRL: rd_word[1:0] = ctrl_q;
            REG_STATUS: rd_word[5:0] = {linear, !push_ready, sleeping,
                                        in_burst, sbs_burst_lo(start_q, step_q, linear)};
            REG_ADDR: rd_word[ADDR_W-1:0] = addr_q;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= sbs_reg_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_proc_load;
        proc_acc |=> addr_q == $past(ADDR);
    endproperty
    a_proc_load: assert property (p_proc_load) else $error("address not loaded");

    property p_start_load;
        strobe_acc |=> (start_q == $past(lo_in)) && (step_q == STEP_RESET);
    endproperty
    a_start_load: assert property (p_start_load) else $error("burst start wrong");

    property p_proc_wins;
        (!PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && !PRIMARY_CHIP_SELECT_N) |-> !push_valid;
    endproperty
    a_proc_wins: assert property (p_proc_wins) else $error("controller strobe used");

    property p_proc_ignored;
        (!PROC_ADDR_STROBE_N && PRIMARY_CHIP_SELECT_N && CTRL_ADDR_STROBE_N)
            |=> $stable(addr_q);
    endproperty
    a_proc_ignored: assert property (p_proc_ignored) else $error("strobe not ignored");

    property p_sleep_entry;
        (sleep_req && !sleeping)[*2] |=> sleeping;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_sleep_quiet;
        sleeping |-> !drain_fire && !DQ_OE && !push_valid;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

    property p_oe_float;
        OUTPUT_ENABLE_N |-> !DQ_OE && !PARITY_IO_OE;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("driving with OE high");

    property p_auto_float;
        (state_q != ST_ACTIVE || wr_inputs) |-> !DQ_OE;
    endproperty
    a_auto_float: assert property (p_auto_float) else $error("driving when it must float");

    property p_step;
        (in_burst && !sleeping && !strobe_acc && !BURST_STEP_N)
            |=> step_q == 2'($past(step_q) + 2'h1);
    endproperty
    a_step: assert property (p_step) else $error("counter did not step");

    property p_global;
        (push_valid && !GLOBAL_WRITE_N) |-> push_data.mask == LANES_ALL;
    endproperty
    a_global: assert property (p_global) else $error("global write not all lanes");

    property p_lanes;
        (push_valid && GLOBAL_WRITE_N) |-> push_data.mask == ~BYTE_LANE_SELECT_N;
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte lane mask wrong");

    property p_hold;
        (!strobe_acc && BURST_STEP_N) |=> $stable(addr_q) && $stable(step_q);
    endproperty
    a_hold: assert property (p_hold) else $error("address changed");

    c_proc_read: cover property (proc_acc ##1 DQ_OE [*2]);
    c_ctrl_write: cover property (ctrl_acc && push_valid);
    c_sleep: cover property (!sleeping ##1 sleeping);
    c_buf_full: cover property (push_valid && !push_ready);

endmodule // sbs_port

//--- sbs_host.sv
// Host model: drives the synchronous SRAM bus and resolves the shared data lines
`timescale 1ns/1ps
module sbs_host (
    // Clock and device outputs
    input wire logic clk,
    input wire logic [31:0] dq_o,
    input wire logic dq_oe,
    input wire logic [3:0] par_o,
    input wire logic par_oe,
    // Bus drive
    output logic [18:0] addr,
    output logic p_n, c_n, cs_n, step_n, gw_n, bwe_n, oe_n, sleep, mode,
    output logic [3:0] bl_n,
    output logic [31:0] dq_i,
    output logic [3:0] par_i
);
    logic [35:0] d_q = 36'h0;
    logic drv_q = 1'b0;
    // Released lines show the inverse of the last value, so a stale copy never passes
    assign dq_i = drv_q ? d_q[35:4] : dq_oe ? dq_o : ~d_q[35:4];
    assign par_i = drv_q ? d_q[3:0] : par_oe ? par_o : ~d_q[3:0];
    initial begin
        {addr, bl_n, p_n, c_n, cs_n, step_n, gw_n, bwe_n, oe_n} = {19'h0, 4'hf, 7'h7e};
        sleep = 1'b0;
        mode = 1'b1;
    end
    // One bus cycle: pins change just after an edge and are sampled at the next
    task automatic cyc(input logic p, c, cs, gw, s, input logic [3:0] bl,
                       input logic [18:0] a, input logic [31:0] d);
        @(posedge clk);
        {p_n, c_n, cs_n, gw_n, step_n, addr} <= {p, c, cs, gw, s, a};
        {bl_n, bwe_n} <= {bl, &bl};
        d_q <= {d, d[3:0]};
        drv_q <= !gw || !(&bl);
        #1;
    endtask
endmodule // sbs_host

//--- tb.sv
// Self-checking testbench for the synchronous burst SRAM port
`timescale 1ns/1ps
module tb;
    import sbs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    wire logic [18:0] addr;
    wire logic p_n, c_n, cs_n, step_n, gw_n, bwe_n, oe_n, sleep, mode, wr_rdy, dq_oe, par_oe;
    wire logic awr, wrdy, bv, arr, rv;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] dq_i, dq_o, rdata;
    wire logic [3:0] bl_n, par_i, par_o;
    int fails = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    sbs_host h (.clk(clk), .dq_o(dq_o), .dq_oe(dq_oe), .par_o(par_o), .par_oe(par_oe),
        .addr(addr), .p_n(p_n), .c_n(c_n), .cs_n(cs_n), .step_n(step_n), .gw_n(gw_n),
        .bwe_n(bwe_n), .oe_n(oe_n), .sleep(sleep), .mode(mode), .bl_n(bl_n),
        .dq_i(dq_i), .par_i(par_i));
    sbs_port dut (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .PROC_ADDR_STROBE_N(p_n),
        .CTRL_ADDR_STROBE_N(c_n), .PRIMARY_CHIP_SELECT_N(cs_n), .BURST_STEP_N(step_n),
        .BURST_ORDER_MODE(mode), .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_ENABLE_N(bwe_n),
        .BYTE_LANE_SELECT_N(bl_n), .WRITE_READY(wr_rdy), .OUTPUT_ENABLE_N(oe_n),
        .SLEEP_REQUEST(sleep), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .PARITY_IO_I(par_i), .PARITY_IO_O(par_o), .PARITY_IO_OE(par_oe),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
    task automatic chk(input logic [35:0] g, e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Stored word for an array index: data in the upper bits, parity nibble below
    function automatic logic [35:0] pat(input logic [7:0] i);
        pat = {24'hc0de00, i, i[3:0]};
    endfunction
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
        chk(bresp, r);
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        {araddr, arv, rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
        chk(rdata, d);
        chk(rresp, r);
    endtask
    task automatic idl(input logic s);
        h.cyc(1'b1, 1'b1, 1'b0, 1'b1, s, 4'hf, 19'h0, 32'h0);
    endtask
    task automatic rd1(input logic [7:0] a, input logic [35:0] e);
        h.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, {11'h0, a}, 32'h0);
        idl(1'b1);
        chk({dq_o, par_o}, e);
    endtask
    task automatic desel;
        h.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 19'h0, 32'h0);
        idl(1'b1);
        chk(dq_oe, 1'b0);
    endtask
    task automatic fill(input logic [7:0] b);
        h.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, {11'h0, b}, 32'(pat(b) >> 4));
        for (int k = 1; k < 4; k++)
            h.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, {11'h0, b}, 32'(pat(8'(b + k)) >> 4));
    endtask
    task automatic t_regs;
        axr(REG_STATUS, 32'h0, RESP_OKAY);
        axr(4'hc, 32'h0, RESP_DECERR);
        axw(4'hc, 32'h1, RESP_DECERR);
        axr(REG_CTRL, 32'h0, RESP_OKAY);
    endtask
    task automatic t_burst(input logic m, input logic [31:0] seq);
        int k;
        @(posedge clk) h.mode <= m;
        h.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, {11'h0, seq[31:24]}, 32'h0);
        for (k = 0; k < 4; k++) begin
            idl(k == 3);
            chk({dq_o, par_o}, pat(seq[31-8*k -: 8]));
            chk(dq_oe, k != 0);
        end
        idl(1'b1);
        chk({dq_o, par_o}, pat(seq[7:0]));
        @(posedge clk) h.oe_n <= 1'b1;
        #1 chk({dq_oe, par_oe}, 2'h0);
        @(posedge clk) h.oe_n <= 1'b0;
        desel;
    endtask
    task automatic t_both;
        h.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, 19'h13, 32'h0);
        // A wrongly taken write commits one edge after capture, so look one edge later
        repeat (3) idl(1'b1);
        chk({dq_o, par_o}, pat(8'h13));
        h.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 19'h55, 32'h0);
        idl(1'b1);
        axr(REG_ADDR, 32'h13, RESP_OKAY);
        axr(REG_STATUS, {~h.mode, 5'h07}, RESP_OKAY);
        desel;
    endtask
    // Held drain lets two writes fill the buffer; the third must be refused
    task automatic t_buf;
        axw(REG_CTRL, 32'h2, RESP_OKAY);
        h.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, 19'h20, 32'h0);
        h.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 19'h20, 32'h0);
        h.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 19'h20, 32'h0);
        chk(wr_rdy, 1'b0);
        idl(1'b1);
        axr(REG_STATUS, {~h.mode, 5'h16}, RESP_OKAY);
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        desel;
        rd1(8'h20, 36'h0);
        rd1(8'h22, pat(8'h22));
    endtask
    task automatic t_sleep;
        desel;
        @(posedge clk) h.sleep <= 1'b1;
        idl(1'b1);
        idl(1'b1);
        axr(REG_STATUS, {~h.mode, 5'h08}, RESP_OKAY);
        @(posedge clk) h.sleep <= 1'b0;
        idl(1'b1);
        idl(1'b1);
        rd1(8'h10, pat(8'h10));
        // Software-forced sleep must behave like the pin
        desel;
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        axr(REG_STATUS, {~h.mode, 5'h08}, RESP_OKAY);
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        idl(1'b1);
        rd1(8'h11, pat(8'h11));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        fill(8'h10);
        fill(8'h20);
        desel;
        t_burst(1'b1, 32'h11_10_13_12);
        t_burst(1'b0, 32'h11_12_13_10);
        h.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'he, 19'h12, 32'hffff_ffff);
        desel;
        rd1(8'h12, {32'hc0de_00ff, 4'h3});
        t_both;
        t_buf;
        t_sleep;
        finish_test;
    end
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        finish_test;
    end
endmodule // tb
